// *** rrs_pkg.sv ***
// constants for the reader status and test register bank
package rrs_pkg;
  localparam logic [7:0] RRS_ADDR_LEVEL   = 8'h0F;
  localparam logic [7:0] RRS_ADDR_TEST1   = 8'h1A;
  localparam logic [7:0] RRS_ADDR_TEST2   = 8'h1B;
  localparam logic [7:0] RRS_ADDR_FILL    = 8'h1C;
  localparam logic [7:0] RRS_TEST_RST     = 8'h00;
  localparam int         RRS_BUF_DEPTH    = 12;
  localparam logic [3:0] RRS_HIGH_MARK    = 4'h9;
  localparam logic [3:0] RRS_LOW_MARK     = 4'h3;
  localparam int         RRS_CLK_MHZ      = 100;
  localparam int         RRS_OSC_US       = 200;
  localparam int         RRS_OSC_CYC      = RRS_OSC_US * RRS_CLK_MHZ;
  // field positions
  localparam int B_KEY_IN   = 7;
  localparam int B_MOD_OUT  = 6;
  localparam int B_DIRECT   = 5;
  localparam int B_OSEL     = 4;
  localparam int B_CUT2     = 3;
  localparam int B_CUT1     = 2;
  localparam int B_AGC      = 0;
  localparam int B_DEC_TEST = 1;
  localparam int B_FASTCLK  = 0;
endpackage : rrs_pkg

// *** rrs_regs.sv ***
// status and test register bank of the reader front end
// Function
// R01: strength values valid reception start to transmit
// R02: latch peak of demodulated envelope
// R03: clear held levels at transmit start
// R04: three-bit level code per channel
// R05: main in bits 2..0, aux 5..3, swappable
// R06: bit 6 oscillator stable, bit 7 zero
// R07: test registers zero at reset/enable low
// R08: test bit 7 routes keying pin to decoder
// R09: test bit 6 drives subcarrier on modpin
// R10: test bit 5 direct modulation, receiver reset
// R11: output select picks receiver stage
// R12: bits 3,2 cut stage gain 6 dB
// R13: agc test shows agc level in main bits
// R14: decoder/io test bits cleared by stop
// R15: test2 bit 0 runs coder fast clock
// R16: fill bit 6 set at nine bytes receiving
// R17: fill bit 5 set at three bytes transmitting
// R18: fill bit 4 flags buffer overflow
// R19: fill bits 3..0 report count minus one
// R20: fill bit 7 reads zero
// R21: buffer irq above eight rx, below four tx
// R22: twelve-byte buffer, overflow sticky until reset
`timescale 1ns/1ps
module rrs_regs
  import rrs_pkg::*;
#(
  parameter int OSC_CYC = RRS_OSC_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       enable,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata,
  input  wire logic       rx_active,
  input  wire logic       tx_start,
  input  wire logic       channel_swap,
  input  wire logic [2:0] first_receive_input,
  input  wire logic [2:0] second_receive_input,
  input  wire logic [2:0] agc_level,
  input  wire logic       osc_running,
  input  wire logic       stop_cond,
  input  wire logic       buf_push,
  input  wire logic       buf_pop,
  input  wire logic       tx_mode,
  input  wire logic       keying_pin,
  input  wire logic       rx_subcarrier,
  input  wire logic       tx_modulation,
  output logic            decoder_subcarrier_in,
  output logic            modulation_pin,
  output logic            receiver_reset,
  output logic            second_stage_out_sel,
  output logic            second_stage_gain_cut,
  output logic            first_stage_gain_cut,
  output logic            decoder_test_mode,
  output logic            coder_fast_clock,
  output logic            buffer_irq_flag
);
  logic [2:0]  main_level_r, aux_level_r;
  logic [7:0]  test1_r, test2_r;
  logic [3:0]  count_r;
  logic        overflow_r, osc_ok_r;
  logic [17:0] osc_cnt_r;
  logic        key_s1_r, key_s2_r, sub_s1_r, sub_s2_r, mod_s1_r, mod_s2_r;
  logic        osc_s1_r, osc_s2_r;
  logic        high_flag, low_flag;
  logic [2:0]  main_src, aux_src, main_view;
  logic [7:0]  level_word, fill_word;
  logic        rst_all;

  assign rst_all = !enable;  // [R07]

  // pin synchronisers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {key_s1_r, key_s2_r, sub_s1_r, sub_s2_r} <= 4'h0;
      {mod_s1_r, mod_s2_r, osc_s1_r, osc_s2_r} <= 4'h0;
    end else begin
      key_s1_r <= keying_pin;
      key_s2_r <= key_s1_r;
      sub_s1_r <= rx_subcarrier;
      sub_s2_r <= sub_s1_r;
      mod_s1_r <= tx_modulation;
      mod_s2_r <= mod_s1_r;
      osc_s1_r <= osc_running;
      osc_s2_r <= osc_s1_r;
    end
  end

  // channel swap picks which input counts as main
  assign main_src = channel_swap ? second_receive_input : first_receive_input;  // [R05]
  assign aux_src  = channel_swap ? first_receive_input : second_receive_input;  // [R05]

  // peak hold, cleared at transmit start
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      main_level_r <= 3'h0;
      aux_level_r  <= 3'h0;
    end else if (rst_all || tx_start) begin  // [R03]
      main_level_r <= 3'h0;
      aux_level_r  <= 3'h0;
    end else if (rx_active) begin  // [R01]
      if (main_src > main_level_r) main_level_r <= main_src;  // [R02] [R04]
      if (aux_src > aux_level_r) aux_level_r <= aux_src;  // [R02] [R04]
    end
  end

  // oscillator settle timer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_cnt_r <= 18'h00000;
      osc_ok_r  <= 1'b0;
    end else if (!osc_s2_r || rst_all) begin
      osc_cnt_r <= 18'h00000;
      osc_ok_r  <= 1'b0;
    end else if (osc_cnt_r >= 18'(OSC_CYC - 1)) begin
      osc_ok_r <= 1'b1;  // [R06]
    end else begin
      osc_cnt_r <= osc_cnt_r + 18'h00001;
    end
  end

  // test registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      test1_r <= RRS_TEST_RST;  // [R07]
      test2_r <= RRS_TEST_RST;  // [R07]
    end else if (rst_all) begin
      test1_r <= RRS_TEST_RST;  // [R07]
      test2_r <= RRS_TEST_RST;  // [R07]
    end else begin
      if (wr_en && addr == RRS_ADDR_TEST1) test1_r <= wdata;
      if (wr_en && addr == RRS_ADDR_TEST2) test2_r <= wdata;
      else if (stop_cond) test2_r[3:1] <= 3'h0;  // [R14]
    end
  end

  // buffer occupancy and overflow
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_r    <= 4'h0;
      overflow_r <= 1'b0;
    end else if (rst_all) begin
      count_r    <= 4'h0;
      overflow_r <= 1'b0;
    end else begin
      if (buf_push && !buf_pop && count_r == 4'(RRS_BUF_DEPTH))
        overflow_r <= 1'b1;  // [R18] [R22]
      if (buf_push && !buf_pop && count_r != 4'(RRS_BUF_DEPTH))
        count_r <= count_r + 4'h1;  // [R22]
      else if (buf_pop && !buf_push && count_r != 4'h0)
        count_r <= count_r - 4'h1;
    end
  end

  assign high_flag = !tx_mode && count_r >= RRS_HIGH_MARK;  // [R16] [R21]
  assign low_flag  = tx_mode && count_r <= RRS_LOW_MARK;  // [R17] [R21]
  assign main_view = test1_r[B_AGC] ? agc_level : main_level_r;  // [R13]
  assign level_word = {1'b0, osc_ok_r, aux_level_r, main_view};  // [R05] [R06]
  assign fill_word = {1'b0, high_flag, low_flag, overflow_r,
                      (count_r == 4'h0) ? 4'h0 : count_r - 4'h1};  // [R19] [R20]

  // read data
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 8'h00;
    end else if (rd_en) begin
      case (addr)
        RRS_ADDR_LEVEL: rdata <= level_word;
        RRS_ADDR_TEST1: rdata <= test1_r;
        RRS_ADDR_TEST2: rdata <= test2_r;
        RRS_ADDR_FILL:  rdata <= fill_word;
        default:        rdata <= 8'h00;
      endcase
    end
  end

  // test outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      decoder_subcarrier_in <= 1'b0;
      modulation_pin        <= 1'b0;
      receiver_reset        <= 1'b0;
      second_stage_out_sel  <= 1'b0;
      second_stage_gain_cut <= 1'b0;
      first_stage_gain_cut  <= 1'b0;
      decoder_test_mode     <= 1'b0;
      coder_fast_clock      <= 1'b0;
      buffer_irq_flag       <= 1'b0;
    end else begin
      decoder_subcarrier_in <= test1_r[B_KEY_IN] ? key_s2_r : sub_s2_r;  // [R08]
      modulation_pin        <= test1_r[B_MOD_OUT] ? sub_s2_r :
                               (test1_r[B_DIRECT] ? mod_s2_r : 1'b0);  // [R09] [R10]
      receiver_reset        <= test1_r[B_DIRECT];  // [R10]
      second_stage_out_sel  <= test1_r[B_OSEL];  // [R11]
      second_stage_gain_cut <= test1_r[B_CUT2];  // [R12]
      first_stage_gain_cut  <= test1_r[B_CUT1];  // [R12]
      decoder_test_mode     <= test2_r[B_DEC_TEST];  // [R14]
      coder_fast_clock      <= test2_r[B_FASTCLK];  // [R15]
      buffer_irq_flag       <= high_flag || low_flag;  // [R21]
    end
  end

  AST_TX_CLEARS: assert property (@(posedge clk) disable iff (!rst_b)  // [R03]
    tx_start |=> main_level_r == 3'h0 && aux_level_r == 3'h0)
    else $error("levels not cleared at transmit");
  AST_PEAK_HOLD: assert property (@(posedge clk) disable iff (!rst_b)  // [R02]
    !tx_start && enable |=> main_level_r >= $past(main_level_r))
    else $error("peak level dropped");
  AST_ENABLE_RST: assert property (@(posedge clk) disable iff (!rst_b)  // [R07]
    !enable |=> test1_r == 8'h00 && test2_r == 8'h00)
    else $error("test registers not zeroed");
  AST_STOP_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)  // [R14]
    stop_cond && !(wr_en && addr == RRS_ADDR_TEST2) |=> test2_r[3:1] == 3'h0)
    else $error("stop did not clear test bits");
  AST_OVF_STICKY: assert property (@(posedge clk) disable iff (!rst_b)  // [R22]
    overflow_r && enable |=> overflow_r)
    else $error("overflow flag dropped");
  AST_OVF_SET: assert property (@(posedge clk) disable iff (!rst_b)  // [R18]
    enable && buf_push && !buf_pop && count_r == 4'hC |=> overflow_r)
    else $error("overflow not flagged");
  AST_IRQ_FLAG: assert property (@(posedge clk) disable iff (!rst_b)  // [R21]
    enable && !tx_mode && count_r == 4'h9 |=> buffer_irq_flag)
    else $error("buffer flag missing at nine");
  AST_FILL_MSB: assert property (@(posedge clk) disable iff (!rst_b)  // [R20]
    rd_en && addr == RRS_ADDR_FILL |=> !rdata[7])
    else $error("reserved bit not zero");
  AST_MOD_ROUTE: assert property (@(posedge clk) disable iff (!rst_b)  // [R09]
    test1_r[B_MOD_OUT] && $stable(test1_r) |=> modulation_pin == $past(sub_s2_r))
    else $error("subcarrier not on modpin");

  // routing, gain cut, test mode, oscillator, level and buffer checks
  AST_OSEL_HIGH: assert property (@(posedge clk) disable iff (!rst_b)  // [R11]
    test1_r[B_OSEL] |=> second_stage_out_sel)
    else $error("second stage not selected");
  AST_OSEL_LOW: assert property (@(posedge clk) disable iff (!rst_b)  // [R11]
    !test1_r[B_OSEL] |=> !second_stage_out_sel)
    else $error("first stage not selected");
  AST_CUT2_ON: assert property (@(posedge clk) disable iff (!rst_b)  // [R12]
    test1_r[B_CUT2] |=> second_stage_gain_cut)
    else $error("second stage cut missing");
  AST_CUT2_OFF: assert property (@(posedge clk) disable iff (!rst_b)  // [R12]
    !test1_r[B_CUT2] |=> !second_stage_gain_cut)
    else $error("second stage cut stuck");
  AST_CUT1_ON: assert property (@(posedge clk) disable iff (!rst_b)  // [R12]
    test1_r[B_CUT1] |=> first_stage_gain_cut)
    else $error("first stage cut missing");
  AST_CUT1_OFF: assert property (@(posedge clk) disable iff (!rst_b)  // [R12]
    !test1_r[B_CUT1] |=> !first_stage_gain_cut)
    else $error("first stage cut stuck");
  AST_KEY_ROUTE: assert property (@(posedge clk) disable iff (!rst_b)  // [R08]
    test1_r[B_KEY_IN] |=> decoder_subcarrier_in == $past(key_s2_r))
    else $error("keying pin not routed to decoder");
  AST_SUB_ROUTE: assert property (@(posedge clk) disable iff (!rst_b)  // [R08]
    !test1_r[B_KEY_IN] |=> decoder_subcarrier_in == $past(sub_s2_r))
    else $error("receiver subcarrier not routed to decoder");
  AST_DIRECT_MOD: assert property (@(posedge clk) disable iff (!rst_b)  // [R10]
    !test1_r[B_MOD_OUT] && test1_r[B_DIRECT] |=> modulation_pin == $past(mod_s2_r))
    else $error("direct modulation not on modpin");
  AST_MOD_IDLE: assert property (@(posedge clk) disable iff (!rst_b)  // [R09] [R10]
    !test1_r[B_MOD_OUT] && !test1_r[B_DIRECT] |=> !modulation_pin)
    else $error("modpin driven while unused");
  AST_RX_RESET: assert property (@(posedge clk) disable iff (!rst_b)  // [R10]
    test1_r[B_DIRECT] |=> receiver_reset)
    else $error("receiver reset missing");
  AST_DEC_MODE: assert property (@(posedge clk) disable iff (!rst_b)  // [R14]
    test2_r[B_DEC_TEST] |=> decoder_test_mode)
    else $error("decoder test mode missing");
  AST_FAST_CLK: assert property (@(posedge clk) disable iff (!rst_b)  // [R15]
    test2_r[B_FASTCLK] |=> coder_fast_clock)
    else $error("coder fast clock missing");
  AST_LEVEL_MSB: assert property (@(posedge clk) disable iff (!rst_b)  // [R06]
    rd_en && addr == RRS_ADDR_LEVEL |=> !rdata[7])
    else $error("unused level bit not zero");
  AST_OSC_LOST: assert property (@(posedge clk) disable iff (!rst_b)  // [R06]
    !osc_s2_r |=> !osc_ok_r)
    else $error("oscillator flag without oscillator");
  AST_OSC_WAIT: assert property (@(posedge clk) disable iff (!rst_b)  // [R06]
    osc_ok_r |-> osc_cnt_r == 18'(OSC_CYC - 1))
    else $error("oscillator flag before settle time");
  AST_MAIN_PEAK: assert property (@(posedge clk) disable iff (!rst_b)  // [R02] [R05]
    rx_active && enable && !tx_start && !channel_swap
    |=> main_level_r >= $past(first_receive_input))
    else $error("main level below first input");
  AST_AUX_PEAK: assert property (@(posedge clk) disable iff (!rst_b)  // [R02] [R05]
    rx_active && enable && !tx_start && !channel_swap
    |=> aux_level_r >= $past(second_receive_input))
    else $error("aux level below second input");
  AST_SWAP_MAIN: assert property (@(posedge clk) disable iff (!rst_b)  // [R05]
    rx_active && enable && !tx_start && channel_swap
    |=> main_level_r >= $past(second_receive_input))
    else $error("swapped main level below second input");
  AST_SWAP_AUX: assert property (@(posedge clk) disable iff (!rst_b)  // [R05]
    rx_active && enable && !tx_start && channel_swap
    |=> aux_level_r >= $past(first_receive_input))
    else $error("swapped aux level below first input");
  AST_IDLE_HOLD: assert property (@(posedge clk) disable iff (!rst_b)  // [R01]
    !rx_active && !tx_start && enable |=> $stable(main_level_r) && $stable(aux_level_r))
    else $error("held levels changed outside reception");
  AST_AGC_VIEW: assert property (@(posedge clk) disable iff (!rst_b)  // [R13]
    rd_en && addr == RRS_ADDR_LEVEL && test1_r[B_AGC] |=> rdata[2:0] == $past(agc_level))
    else $error("agc level not shown");
  AST_FILL_HIGH: assert property (@(posedge clk) disable iff (!rst_b)  // [R16]
    rd_en && addr == RRS_ADDR_FILL && !tx_mode && count_r >= 4'h9 |=> rdata[6])
    else $error("high level flag missing");
  AST_FILL_LOW: assert property (@(posedge clk) disable iff (!rst_b)  // [R17]
    rd_en && addr == RRS_ADDR_FILL && tx_mode && count_r <= 4'h3 |=> rdata[5])
    else $error("low level flag missing");
  AST_FILL_COUNT: assert property (@(posedge clk) disable iff (!rst_b)  // [R19]
    rd_en && addr == RRS_ADDR_FILL && count_r == 4'h8 |=> rdata[3:0] == 4'h7)
    else $error("byte count not reported minus one");
  AST_COUNT_MAX: assert property (@(posedge clk) disable iff (!rst_b)  // [R22]
    count_r <= 4'hC)
    else $error("buffer count beyond depth");
endmodule : rrs_regs

// *** rrs_host.sv ***
// host controller model driving register reads and writes
`timescale 1ns/1ps
module rrs_host (
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  output logic            wr_en,
  output logic            rd_en,
  output logic      [7:0] addr,
  output logic      [7:0] wdata
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr  = 8'h00;
    wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    addr  = a;
    wdata = v;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk);
    addr  = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    v     = rdata;
  endtask : rd
endmodule : rrs_host

// *** tb_rrs_regs.sv ***
// self-checking bench for the reader status and test registers
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module tb_rrs_regs;
  import rrs_pkg::*;
  logic clk, rst_b, enable, wr_en, rd_en, rx_active, tx_start, channel_swap, osc_running;
  logic stop_cond, buf_push, buf_pop, tx_mode, keying_pin, rx_subcarrier, tx_modulation;
  logic [7:0] addr, wdata, rdata, v, d;
  logic [2:0] first_receive_input, second_receive_input, agc_level;
  logic decoder_subcarrier_in, modulation_pin, receiver_reset, second_stage_out_sel;
  logic second_stage_gain_cut, first_stage_gain_cut, decoder_test_mode, coder_fast_clock;
  logic buffer_irq_flag;
  int   mismatches, tests_run, n;
  rrs_host h (.clk, .rdata, .wr_en, .rd_en, .addr, .wdata);
  rrs_regs #(.OSC_CYC(10)) DUT (.clk, .rst_b, .enable, .wr_en, .rd_en, .addr, .wdata,
    .rdata, .rx_active, .tx_start, .channel_swap, .first_receive_input,
    .second_receive_input, .agc_level, .osc_running, .stop_cond, .buf_push, .buf_pop,
    .tx_mode, .keying_pin, .rx_subcarrier, .tx_modulation, .decoder_subcarrier_in,
    .modulation_pin, .receiver_reset, .second_stage_out_sel, .second_stage_gain_cut,
    .first_stage_gain_cut, .decoder_test_mode, .coder_fast_clock, .buffer_irq_flag);
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  function automatic logic [7:0] fill_exp(int c, logic tx, logic ov);
    return {1'b0, !tx && c >= 9, tx && c <= 3, ov, 4'(c > 0 ? c - 1 : 0)};
  endfunction : fill_exp
  task automatic pulse(input bit p);
    @(negedge clk);
    if (p) buf_push = 1'b1;
    else buf_pop = 1'b1;
    @(negedge clk);
    buf_push = 1'b0;
    buf_pop  = 1'b0;
  endtask : pulse
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #500us;
    mismatches++;
    results();
  end
  initial begin
    {rst_b, rx_active, tx_start, channel_swap, osc_running, stop_cond} = '0;
    {buf_push, buf_pop, tx_mode, keying_pin, rx_subcarrier, tx_modulation} = '0;
    {first_receive_input, second_receive_input, agc_level} = '0;
    enable = 1'b1;
    void'($urandom(74368));
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    osc_running = 1'b1;
    h.rd(RRS_ADDR_TEST1, d); `CHK("t1_rst", 8'h00, d)
    h.rd(RRS_ADDR_TEST2, d); `CHK("t2_rst", 8'h00, d)
    h.rd(RRS_ADDR_FILL, d); `CHK("fill_rst", 8'h00, d)
    h.rd(8'h55, d); `CHK("unmapped", 8'h00, d)
    repeat (4) begin
      v = 8'($urandom) & 8'hFE;
      {keying_pin, rx_subcarrier, tx_modulation} = 3'($urandom);
      h.wr(RRS_ADDR_TEST1, v);
      repeat (2) @(negedge clk);
      h.rd(RRS_ADDR_TEST1, d); `CHK("test1", v, d)
      `CHK("osel", v[4], second_stage_out_sel)
      `CHK("cut", v[3:2], {second_stage_gain_cut, first_stage_gain_cut})
      `CHK("modpin", v[6] ? rx_subcarrier : v[5] & tx_modulation, modulation_pin)
      `CHK("rxrst", v[5], receiver_reset)
      `CHK("keyin", v[7] ? keying_pin : rx_subcarrier, decoder_subcarrier_in)
    end
    h.wr(RRS_ADDR_TEST2, 8'h0F);
    repeat (2) @(negedge clk);
    `CHK("dectest", 1'b1, decoder_test_mode)
    `CHK("fastclk", 1'b1, coder_fast_clock)
    stop_cond = 1'b1;
    @(negedge clk);
    stop_cond = 1'b0;
    h.rd(RRS_ADDR_TEST2, d); `CHK("stop", 8'h01, d)
    `CHK("dectest_off", 1'b0, decoder_test_mode)
    $display("test registers done");
    rx_active = 1'b1;
    first_receive_input = 3'd5;
    second_receive_input = 3'd3;
    repeat (3) @(negedge clk);
    first_receive_input = 3'd1;
    h.rd(RRS_ADDR_LEVEL, d); `CHK("peak", 8'h5D, d)
    rx_active = 1'b0;
    tx_start = 1'b1;
    @(negedge clk);
    tx_start = 1'b0;
    h.rd(RRS_ADDR_LEVEL, d); `CHK("clear", 8'h40, d)
    channel_swap = 1'b1;
    rx_active = 1'b1;
    first_receive_input = 3'd2;
    second_receive_input = 3'd6;
    repeat (3) @(negedge clk);
    h.rd(RRS_ADDR_LEVEL, d); `CHK("swap", 8'h56, d)
    agc_level = 3'd3;
    h.wr(RRS_ADDR_TEST1, 8'h01);
    h.rd(RRS_ADDR_LEVEL, d); `CHK("agc", 8'h53, d)
    $display("levels done");
    rx_active = 1'b0;
    for (n = 1; n <= 13; n++) begin
      pulse(1'b1);
      h.rd(RRS_ADDR_FILL, d);
      `CHK("fill_rx", fill_exp(n > 12 ? 12 : n, 1'b0, n > 12), d)
      `CHK("irq_rx", n > 8, buffer_irq_flag)
    end
    tx_mode = 1'b1;
    for (n = 11; n >= 0; n--) begin
      pulse(1'b0);
      h.rd(RRS_ADDR_FILL, d); `CHK("fill_tx", fill_exp(n, 1'b1, 1'b1), d)
      `CHK("irq_tx", n < 4, buffer_irq_flag)
    end
    enable = 1'b0;
    @(negedge clk);
    enable = 1'b1;
    h.rd(RRS_ADDR_TEST1, d); `CHK("en_low", 8'h00, d)
    `CHK("fastclk_off", 1'b0, coder_fast_clock)
    h.rd(RRS_ADDR_FILL, d); `CHK("fill_en", fill_exp(0, 1'b1, 1'b0), d)
    h.rd(RRS_ADDR_LEVEL, d); `CHK("osc_wait", 8'h00, d)
    repeat (12) @(negedge clk);
    h.rd(RRS_ADDR_LEVEL, d); `CHK("osc_ok", 8'h40, d)
    $display("buffer done");
    results();
  end
endmodule : tb_rrs_regs
